// [include/dbuc_defines.svh]
/*
  Constants of the DAC bank update control: bank layout, code range,
  serial-clock delays and core-clock timing counts.
  Assumes a 200 MHz core clock and a host-supplied serial clock.
*/
`ifndef DBUC_DEFINES_SVH
`define DBUC_DEFINES_SVH

`define DBUC_NUM_BANKS        2
`define DBUC_DACS_PER_BANK    16
`define DBUC_CODE_W           16
`define DBUC_IDX_W            4
`define DBUC_CODE_MIN         16'h0000
`define DBUC_CODE_MAX         16'hffff
`define DBUC_CODE_RESET       16'h0000

// level indices inside a bank
`define DBUC_IDX_DRV_HIGH     4'h1
`define DBUC_IDX_DRV_LOW      4'h3
`define DBUC_IDX_OVD_HIGH     4'he
`define DBUC_IDX_OVD_LOW      4'hf

// serial clock edges after chip select release
`define DBUC_TRIG_DELAY_SCLK  4
`define DBUC_BUSY_DRV_SCLK    21
`define DBUC_BUSY_DAC_SCLK    18
`define DBUC_BUSY_CTRL_SCLK   3

// core clock timing
`define DBUC_CORE_CLK_MHZ     200
`define DBUC_DEGLITCH_NS      3000
`define DBUC_SETTLE_NS        7000
`define DBUC_DEGLITCH_CYC     ((`DBUC_DEGLITCH_NS * `DBUC_CORE_CLK_MHZ + 999) / 1000)
`define DBUC_SETTLE_CYC       ((`DBUC_SETTLE_NS * `DBUC_CORE_CLK_MHZ + 999) / 1000)

`endif

// [include/dbuc_pkg.sv]
/*
  Types of the DAC bank update control: codes, bank images, the decoded
  serial write and the per-bank control bits, and the trigger states.
  Assumes dbuc_defines.svh is on the include path.
*/
`include "dbuc_defines.svh"

package dbuc_pkg;

  typedef logic [`DBUC_CODE_W-1:0] dbuc_code_type;

  typedef dbuc_code_type [`DBUC_DACS_PER_BANK-1:0] dbuc_bank_type;

  typedef struct packed {
    logic                       dacWrite;
    logic [`DBUC_IDX_W-1:0]     index;
    logic [`DBUC_NUM_BANKS-1:0] chanSel;
    dbuc_code_type              code;
  } dbuc_write_type;

  typedef struct packed {
    logic                       ctrlWrite;
    logic [`DBUC_NUM_BANKS-1:0] deferred;
    logic [`DBUC_NUM_BANKS-1:0] loadStrobe;
  } dbuc_ctrl_type;

  typedef enum logic [0:0] {
    DBUC_IDLE  = 1'b0,
    DBUC_DELAY = 1'b1
  } dbuc_trig_state_type;

endpackage : dbuc_pkg

// [src/dbuc_deglitch_timer.sv]
/*
  Retriggerable one-shot timer on the core clock.
  Assumes trigger is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dbuc_deglitch_timer #(
  parameter int unsigned COUNT = 600
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clkEn,
  input  wire logic trigger,
  output logic      active,
  output logic      expire
);

  localparam int unsigned W = $clog2(COUNT + 1);

  logic [W-1:0] remain;

  if (COUNT < 2) begin : badCount
    $error("dbuc_deglitch_timer: COUNT must be at least 2");
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      remain <= '0;
    end else if (clkEn) begin
      if (trigger) begin
        remain <= W'(COUNT);
      end else if (remain != '0) begin
        remain <= remain - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      expire <= 1'b0;
    end else if (clkEn) begin
      expire <= !trigger && (remain == W'(1));
    end
  end

  assign active = (remain != '0) || expire;

endmodule : dbuc_deglitch_timer

`default_nettype wire

// [src/dbuc_update_control.sv]
/*
  DAC bank update control: queues serial DAC writes per channel bank,
  triggers bank updates in immediate or deferred mode, and applies
  queued codes after each bank's deglitch interval.
  Assumes an SPI front end on the serial clock presents the decoded
  write and control bits, stable from chip select low until the first
  serial clock edge after chip select release.
*/
`timescale 1ns/1ps
`default_nettype none

module dbuc_update_control #(
  parameter int unsigned NUM_BANKS     = `DBUC_NUM_BANKS,
  parameter int unsigned DACS_PER_BANK = `DBUC_DACS_PER_BANK,
  parameter int unsigned CODE_W        = `DBUC_CODE_W,
  parameter int unsigned DEGLITCH_CYC  = `DBUC_DEGLITCH_CYC,
  parameter int unsigned SETTLE_CYC    = `DBUC_SETTLE_CYC
) (
  input  wire logic                                    core_clk,
  input  wire logic                                    coreEn,
  input  wire logic                                    sys_rst,
  input  wire logic                                    sclkLink,
  input  wire logic                                    csN,
  input  wire dbuc_pkg::dbuc_write_type                spiWrite,
  input  wire dbuc_pkg::dbuc_ctrl_type                 spiCtrl,
  output var  dbuc_pkg::dbuc_bank_type [NUM_BANKS-1:0] appliedLevel,
  output logic [NUM_BANKS-1:0]                         bankDeglitch,
  output logic [NUM_BANKS-1:0]                         bankSettling,
  output logic                                         sclkBusy
);

  // layout fixed by the carrier types
  if (NUM_BANKS != `DBUC_NUM_BANKS || DACS_PER_BANK != `DBUC_DACS_PER_BANK
      || CODE_W != `DBUC_CODE_W) begin : badLayout
    $error("dbuc_update_control: layout must match dbuc_pkg types");
  end

  if (DEGLITCH_CYC < 2 || SETTLE_CYC < 2) begin : badTiming
    $error("dbuc_update_control: timing counts must be at least 2");
  end

  if (`DBUC_TRIG_DELAY_SCLK < 2 || `DBUC_TRIG_DELAY_SCLK > 9
      || `DBUC_BUSY_DRV_SCLK < 1 || `DBUC_BUSY_DRV_SCLK > 32 || `DBUC_BUSY_DAC_SCLK < 1
      || `DBUC_BUSY_DAC_SCLK > 32 || `DBUC_BUSY_CTRL_SCLK < 1) begin : badSclkCounts
    $error("dbuc_update_control: serial clock counts out of counter range");
  end

  localparam logic [2:0] TRIG_LOAD = 3'(`DBUC_TRIG_DELAY_SCLK - 2);
  localparam logic [4:0] BUSY_DRV  = 5'(`DBUC_BUSY_DRV_SCLK - 1);
  localparam logic [4:0] BUSY_DAC  = 5'(`DBUC_BUSY_DAC_SCLK - 1);
  localparam logic [4:0] BUSY_CTRL = 5'(`DBUC_BUSY_CTRL_SCLK - 1);

  // banks a valid write lands in
  function automatic logic [NUM_BANKS-1:0] bankHits(
    input dbuc_pkg::dbuc_write_type wr
  );
    bankHits = wr.chanSel & {NUM_BANKS{wr.dacWrite}};
  endfunction : bankHits

  // banks whose analog update a release starts
  function automatic logic [NUM_BANKS-1:0] updateRequest(
    input logic [NUM_BANKS-1:0] hit,
    input dbuc_pkg::dbuc_ctrl_type ctrl,
    input logic [NUM_BANKS-1:0] deferred
  );
    logic [NUM_BANKS-1:0] strobe;
    strobe = ctrl.loadStrobe & {NUM_BANKS{ctrl.ctrlWrite}};
    updateRequest = (hit & ~deferred) | (strobe & deferred);
  endfunction : updateRequest

  // driver levels need the longest serial tail
  function automatic logic isDriverLevel(
    input logic [`DBUC_IDX_W-1:0] idx
  );
    isDriverLevel = (idx == `DBUC_IDX_DRV_HIGH) || (idx == `DBUC_IDX_DRV_LOW);
  endfunction : isDriverLevel

  // serial clock domain

  logic linkRstMeta;
  logic linkRst;

  // reset crossing into the serial clock domain; held until clocks run
  always_ff @(posedge sclkLink) begin
    linkRstMeta <= sys_rst;
    linkRst     <= linkRstMeta;
  end

  // csN is launched by the host against sclkLink, no resync needed
  logic csPrevN;
  logic csRelease;

  always_ff @(posedge sclkLink) begin
    if (linkRst) begin
      csPrevN <= 1'b1;
    end else begin
      csPrevN <= csN;
    end
  end

  assign csRelease = csN && !csPrevN;

  // per-bank mode held in the link domain
  logic [NUM_BANKS-1:0] deferredMode;
  logic [NUM_BANKS-1:0] next_deferredMode;

  always_comb begin
    next_deferredMode = deferredMode;
    if (csRelease && spiCtrl.ctrlWrite) begin
      next_deferredMode = spiCtrl.deferred;
    end
  end

  always_ff @(posedge sclkLink) begin
    if (linkRst) begin
      deferredMode <= '0;
    end else begin
      deferredMode <= next_deferredMode;
    end
  end

  logic [NUM_BANKS-1:0] writeHit;
  logic [NUM_BANKS-1:0] releaseReq;

  assign writeHit = bankHits(spiWrite);
  // strobe counts only for deferred banks; no request
  assign releaseReq = csRelease ? updateRequest(writeHit, spiCtrl, next_deferredMode)
                                : '0;

  dbuc_pkg::dbuc_bank_type [NUM_BANKS-1:0] queuedLevel;

  // store at addressed level only; both banks on dual write
  always_ff @(posedge sclkLink) begin
    if (linkRst) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        for (int i = 0; i < DACS_PER_BANK; i++) begin
          queuedLevel[b][i] <= `DBUC_CODE_RESET;
        end
      end
    end else if (csRelease) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        // any code from full range accepted
        if (writeHit[b]) begin
          queuedLevel[b][spiWrite.index] <= spiWrite.code;
        end
      end
    end
  end

  dbuc_pkg::dbuc_trig_state_type trigState;
  logic [2:0]                    trigCount;
  logic [NUM_BANKS-1:0]          pendingBanks;
  logic                          trigFire;

  assign trigFire = (trigState == dbuc_pkg::DBUC_DELAY) && (trigCount == 3'h0);

  // fire on fourth serial edge after release
  always_ff @(posedge sclkLink) begin
    if (linkRst) begin
      trigState    <= dbuc_pkg::DBUC_IDLE;
      trigCount    <= 3'h0;
      pendingBanks <= '0;
    end else begin
      case (trigState)
        dbuc_pkg::DBUC_IDLE: begin
          if (releaseReq != '0) begin
            trigState    <= dbuc_pkg::DBUC_DELAY;
            trigCount    <= TRIG_LOAD;
            pendingBanks <= releaseReq;
          end
        end
        dbuc_pkg::DBUC_DELAY: begin
          if (releaseReq != '0) begin
            trigCount    <= TRIG_LOAD;
            pendingBanks <= trigFire ? releaseReq : (pendingBanks | releaseReq);
          end else if (trigFire) begin
            trigState    <= dbuc_pkg::DBUC_IDLE;
            pendingBanks <= '0;
          end else begin
            trigCount <= trigCount - 3'h1;
          end
        end
        default: begin
          trigState    <= dbuc_pkg::DBUC_IDLE;
          trigCount    <= 3'h0;
          pendingBanks <= '0;
        end
      endcase
    end
  end

  // snapshot stays still for at least three serial clocks after each update
  dbuc_pkg::dbuc_bank_type [NUM_BANKS-1:0] snapLevel;
  logic [NUM_BANKS-1:0]                    updToggle;

  // whole bank image incl. earlier queued codes; same on strobe
  always_ff @(posedge sclkLink) begin
    if (linkRst) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        for (int i = 0; i < DACS_PER_BANK; i++) begin
          snapLevel[b][i] <= `DBUC_CODE_RESET;
        end
      end
      updToggle <= '0;
    end else if (trigFire) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (pendingBanks[b]) begin
          snapLevel[b] <= queuedLevel[b];
          updToggle[b] <= !updToggle[b];
        end
      end
    end
  end

  logic [4:0] busyCount;

  // tell the host how long serial clocks are still needed
  always_ff @(posedge sclkLink) begin
    if (linkRst) begin
      busyCount <= 5'h00;
    end else if (csRelease && spiWrite.dacWrite) begin
      if (isDriverLevel(spiWrite.index)) begin
        busyCount <= BUSY_DRV;
      end else begin
        busyCount <= BUSY_DAC;
      end
    end else if (csRelease && spiCtrl.ctrlWrite) begin
      busyCount <= BUSY_CTRL;
    end else if (busyCount != 5'h00) begin
      busyCount <= busyCount - 5'h01;
    end
  end

  // trigger counted on serial edges, so clock must run
  assign sclkBusy = (busyCount != 5'h00) || (trigState == dbuc_pkg::DBUC_DELAY);

  // core clock domain

  for (genvar b = 0; b < NUM_BANKS; b++) begin : bank
    logic tglMeta;
    logic tglSync;
    logic tglSeen;
    logic updatePulse;
    logic deglitchActive;
    logic deglitchDone;
    logic settleActive;
    dbuc_pkg::dbuc_bank_type heldLevel;

    // two updates inside one freeze cancel out; keep freezes short
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        tglMeta <= 1'b0;
        tglSync <= 1'b0;
        tglSeen <= 1'b0;
      end else if (coreEn) begin
        tglMeta <= updToggle[b];
        tglSync <= tglMeta;
        tglSeen <= tglSync;
      end
    end

    assign updatePulse = tglSync ^ tglSeen;

    // capture only once the toggle is through; snapLevel then stays
    // still for at least three serial clocks, so the wide word crosses safely
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        for (int i = 0; i < DACS_PER_BANK; i++) begin
          heldLevel[i] <= `DBUC_CODE_RESET;
        end
      end else if (coreEn && updatePulse) begin
        heldLevel <= snapLevel[b];
      end
    end

    // own timer per bank; retriggered by each pulse
    dbuc_deglitch_timer #(
      .COUNT (DEGLITCH_CYC)
    ) deglitchTimer (
      .clk     (core_clk),
      .rst     (sys_rst),
      .clkEn   (coreEn),
      .trigger (updatePulse),
      .active  (deglitchActive),
      .expire  (deglitchDone)
    );

    dbuc_deglitch_timer #(
      .COUNT (SETTLE_CYC)
    ) settleTimer (
      .clk     (core_clk),
      .rst     (sys_rst),
      .clkEn   (coreEn),
      .trigger (deglitchDone),
      .active  (settleActive),
      .expire  ()
    );

    // codes move only at deglitch end; thresholds included
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        for (int i = 0; i < DACS_PER_BANK; i++) begin
          appliedLevel[b][i] <= `DBUC_CODE_RESET;
        end
      end else if (coreEn && deglitchDone) begin
        appliedLevel[b] <= heldLevel;
      end
    end

    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        bankDeglitch[b] <= 1'b0;
        bankSettling[b] <= 1'b0;
      end else if (coreEn) begin
        bankDeglitch[b] <= deglitchActive || updatePulse;
        bankSettling[b] <= deglitchActive || updatePulse || settleActive;
      end
    end
  end

endmodule : dbuc_update_control

`default_nettype wire

// [tb/dbuc_host_model.sv]
/*
  Serial host model: makes the link clock only within frames, busy tails and direct tick calls.
  Assumes the bench calls tick and frame hierarchically.
*/
`timescale 1ns/1ps
`default_nettype none

module dbuc_host_model (
  output logic                     sclkLink,
  output logic                     csN,
  output dbuc_pkg::dbuc_write_type spiWrite,
  output dbuc_pkg::dbuc_ctrl_type  spiCtrl,
  input  wire logic                sclkBusy
);
  initial begin
    sclkLink = 1'b0;
    csN = 1'b1;
    spiWrite = '0;
    spiCtrl = '0;
  end

  task automatic tick(input int n);
    repeat (n) begin
      #80 sclkLink = 1'b1;
      #80 sclkLink = 1'b0;
    end
  endtask : tick

  task automatic frame(input dbuc_pkg::dbuc_write_type w, input dbuc_pkg::dbuc_ctrl_type c,
                       input bit hold);
    int n;
    // offset keeps serial edges off the core clock edges
    #37;
    spiWrite = w;
    spiCtrl = c;
    csN = 1'b0;
    tick(2);
    csN = 1'b1;
    tick(1);
    spiWrite = ~spiWrite;
    spiCtrl = ~spiCtrl;
    tick(3);
    n = 0;
    while (hold && sclkBusy !== 1'b0 && n < 40) begin
      tick(1);
      n++;
    end
  endtask : frame
endmodule : dbuc_host_model

`default_nettype wire

// [tb/dbuc_update_control_assertions.sv]
/*
  Concurrent checks on the ports of the DAC bank update control.
  Assumes binding into dbuc_update_control; the link checks use sys_rst.
*/
`timescale 1ns/1ps
`default_nettype none

module dbuc_update_control_assertions #(
  parameter int unsigned NUM_BANKS  = 2,
  parameter int unsigned SETTLE_CYC = 8
) (
  input wire logic                                    core_clk,
  input wire logic                                    sys_rst,
  input wire logic                                    sclkLink,
  input wire logic                                    csN,
  input wire dbuc_pkg::dbuc_write_type                spiWrite,
  input wire dbuc_pkg::dbuc_ctrl_type                 spiCtrl,
  input wire dbuc_pkg::dbuc_bank_type [NUM_BANKS-1:0] appliedLevel,
  input wire logic [NUM_BANKS-1:0]                    bankDeglitch,
  input wire logic [NUM_BANKS-1:0]                    bankSettling,
  input wire logic                                    sclkBusy
);
  localparam int SLIM = SETTLE_CYC + 8;

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    sequence s_dgRun;
      bankDeglitch[b] [*8];
    endsequence
    property p_apply;
      @(posedge core_clk) disable iff (sys_rst)
      $changed(appliedLevel[b]) |-> $past(bankDeglitch[b]);
    endproperty
    property p_dgMin;
      @(posedge core_clk) disable iff (sys_rst) $rose(bankDeglitch[b]) |-> s_dgRun;
    endproperty
    property p_dgSettle;
      @(posedge core_clk) disable iff (sys_rst) bankDeglitch[b] |-> bankSettling[b];
    endproperty
    property p_tail;
      @(posedge core_clk) disable iff (sys_rst)
      $fell(bankDeglitch[b]) |-> ##[1:SLIM] (!bankSettling[b] || bankDeglitch[b]);
    endproperty
    property p_setStart;
      @(posedge core_clk) disable iff (sys_rst) $rose(bankSettling[b]) |-> bankDeglitch[b];
    endproperty
    a_apply: assert property (p_apply) else $error("level changed outside deglitch");
    a_dgMin: assert property (p_dgMin) else $error("deglitch too short");
    a_dgSettle: assert property (p_dgSettle) else $error("deglitch without settle");
    a_tail: assert property (p_tail) else $error("settle not ended in time");
    a_setStart: assert property (p_setStart) else $error("settle began alone");
  end

  property p_busyUp;
    @(posedge sclkLink) disable iff (sys_rst)
    $rose(csN) && spiWrite.dacWrite |=> sclkBusy [*8];
  endproperty
  property p_busyEnd;
    @(posedge sclkLink) disable iff (sys_rst) $rose(csN) |-> ##[1:40] !sclkBusy;
  endproperty
  property p_busyCtrl;
    @(posedge sclkLink) disable iff (sys_rst)
    $rose(csN) && spiCtrl.ctrlWrite && !spiWrite.dacWrite |-> ##[1:6] !sclkBusy;
  endproperty
  a_busyUp: assert property (p_busyUp) else $error("busy short after write");
  a_busyEnd: assert property (p_busyEnd) else $error("busy never ends");
  a_busyCtrl: assert property (p_busyCtrl) else $error("busy long after control");
endmodule : dbuc_update_control_assertions

bind dbuc_update_control dbuc_update_control_assertions #(
  .NUM_BANKS(NUM_BANKS), .SETTLE_CYC(SETTLE_CYC)
) u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .sclkLink(sclkLink), .csN(csN),
  .spiWrite(spiWrite), .spiCtrl(spiCtrl), .appliedLevel(appliedLevel),
  .bankDeglitch(bankDeglitch), .bankSettling(bankSettling), .sclkBusy(sclkBusy)
);

`default_nettype wire

// [tb/test_dbuc_update_control.sv]
/*
  Self-checking bench of the DAC bank update control.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbuc_defines.svh"

module test_dbuc_update_control;
  localparam int DG = 300;
  localparam int ST = 40;
  logic                          core_clk;
  logic                          coreEn;
  logic                          sys_rst;
  logic                          sclkLink;
  logic                          csN;
  logic                          sclkBusy;
  logic                          clr;
  logic                          csP;
  logic                          dgP;
  dbuc_pkg::dbuc_write_type      spiWrite;
  dbuc_pkg::dbuc_ctrl_type       spiCtrl;
  dbuc_pkg::dbuc_bank_type [1:0] lv;
  dbuc_pkg::dbuc_bank_type [1:0] ex;
  logic [1:0]                    bankDeglitch;
  logic [1:0]                    bankSettling;
  int                            errors;
  int                            check_count;
  int                            dg[2];
  int                            lat;
  int                            rl;

  dbuc_update_control #(.DEGLITCH_CYC(DG), .SETTLE_CYC(ST)) DUT (
    .core_clk(core_clk), .coreEn(coreEn), .sys_rst(sys_rst), .sclkLink(sclkLink),
    .csN(csN), .spiWrite(spiWrite), .spiCtrl(spiCtrl), .appliedLevel(lv),
    .bankDeglitch(bankDeglitch), .bankSettling(bankSettling), .sclkBusy(sclkBusy));
  dbuc_host_model host (.sclkLink(sclkLink), .csN(csN), .spiWrite(spiWrite),
    .spiCtrl(spiCtrl), .sclkBusy(sclkBusy));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // deglitch cycles per bank, release-to-deglitch latency
  always @(posedge core_clk) begin
    csP <= csN;
    dgP <= bankDeglitch[0];
    lat <= (csN && !csP) ? 0 : lat + 1;
    if (bankDeglitch[0] && !dgP) rl <= lat;
    for (int b = 0; b < 2; b++) dg[b] <= clr ? 0 : dg[b] + int'(bankDeglitch[b]);
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
    check_count++;
    if (a !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, a);
    end
  endtask : chk

  task automatic cmpAll;
    for (int b = 0; b < 2; b++)
      for (int i = 0; i < 16; i++)
        chk($sformatf("level%0d_%0d", b, i), ex[b][i], lv[b][i]);
  endtask : cmpAll

  function automatic dbuc_pkg::dbuc_write_type wr(logic [3:0] i, logic [1:0] s, logic [15:0] c);
    return '{1'b1, i, s, c};
  endfunction : wr

  function automatic dbuc_pkg::dbuc_ctrl_type cw(logic [1:0] d, logic [1:0] l);
    return '{1'b1, d, l};
  endfunction : cw

  task automatic clear;
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
  endtask : clear

  task automatic settle;
    int n;
    n = 0;
    repeat (4) @(posedge core_clk);
    while (bankSettling !== 2'b00 && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    chk("settling", 0, bankSettling);
  endtask : settle

  task automatic run(input dbuc_pkg::dbuc_write_type w, input dbuc_pkg::dbuc_ctrl_type c);
    clear();
    host.frame(w, c, 1'b1);
    settle();
    chk("busy", 0, sclkBusy);
  endtask : run

  task automatic t_imm;
    run(wr(`DBUC_IDX_DRV_HIGH, 2'b01, `DBUC_CODE_MAX), '0);
    ex[0][1] = `DBUC_CODE_MAX;
    cmpAll();
    chk("deglitch0", 1, dg[0] >= DG && dg[0] <= DG + 2);
    chk("deglitch1", 0, dg[1]);
    chk("latency", 1, rl >= 110 && rl <= 120);
  endtask : t_imm

  task automatic t_mode;
    run('0, cw(2'b10, 2'b00));
    run(wr(`DBUC_IDX_OVD_HIGH, 2'b11, 16'h1234), '0);
    ex[0][14] = 16'h1234;
    cmpAll();
    chk("deglitch1", 0, dg[1]);
    run('0, cw(2'b10, 2'b11));
    ex[1][14] = 16'h1234;
    cmpAll();
    chk("deglitch0", 0, dg[0]);
    chk("deglitch1", 1, dg[1] >= DG && dg[1] <= DG + 2);
  endtask : t_mode

  task automatic t_requeue;
    run(wr(`DBUC_IDX_DRV_LOW, 2'b10, 16'h00aa), '0);
    run('0, cw(2'b00, 2'b00));
    cmpAll();
    run(wr(4'h0, 2'b10, 16'h0001), '0);
    ex[1][3] = 16'h00aa;
    ex[1][0] = 16'h0001;
    cmpAll();
  endtask : t_requeue

  task automatic t_retrig;
    clear();
    host.frame(wr(4'h5, 2'b01, 16'h5555), '0, 1'b0);
    host.frame(wr(4'h5, 2'b01, 16'haaaa), '0, 1'b1);
    settle();
    ex[0][5] = 16'haaaa;
    cmpAll();
    chk("retrigger", 1, dg[0] > DG + 100);
  endtask : t_retrig

  task automatic t_freeze;
    clear();
    host.frame(wr(4'h5, 2'b01, 16'h0f0f), '0, 1'b0);
    @(posedge core_clk);
    coreEn <= 1'b0;
    repeat (50) @(posedge core_clk);
    coreEn <= 1'b1;
    host.tick(20);
    settle();
    ex[0][5] = 16'h0f0f;
    cmpAll();
    chk("freeze", 1, dg[0] >= DG + 50 && dg[0] <= DG + 52);
    chk("busy", 0, sclkBusy);
  endtask : t_freeze

  task automatic summarize;
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  initial begin
    #200000;
    errors++;
    summarize();
  end

  initial begin
    coreEn = 1'b1;
    sys_rst = 1'b1;
    clr = 1'b0;
    ex = '0;
    errors = 0;
    check_count = 0;
    repeat (3) @(posedge core_clk);
    // link side needs its own edges in reset
    host.tick(3);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    host.tick(4);
    cmpAll();
    chk("busy", 0, sclkBusy);
    t_imm();
    t_mode();
    t_requeue();
    t_retrig();
    t_freeze();
    summarize();
  end
endmodule : test_dbuc_update_control

`default_nettype wire
